// >>> rtl/gmx_cfg.svh
`ifndef GMX_CFG_SVH
`define GMX_CFG_SVH

// Sizes.
`define GMX_NPINS        6
`define GMX_NFLAGS       24
`define GMX_NSTROBES     16
`define GMX_ADDR_W       4
`define GMX_DATA_W       32
`define GMX_DIV_W        8

// Register offsets; control registers sit at offsets 0 to 5.
`define GMX_A_CTRL0      4'h0
`define GMX_A_POL        4'h6
`define GMX_A_COLLA      4'h7
`define GMX_A_CLKDIV     4'h8
`define GMX_A_ISTAT      4'h9
`define GMX_A_IMASK      4'hA
`define GMX_A_PINLVL     4'hB
`define GMX_A_LAST       4'hC

// Function codes.
`define GMX_CODE_CLOCK       7'h00
`define GMX_CODE_FLAG_FIRST  7'h01
`define GMX_CODE_FLAG_LAST   7'h18
`define GMX_CODE_STROBE_LAST 7'h0F
`define GMX_CODE_COLL_A      7'h21
`define GMX_CODE_DRIVE_LOW   7'h7E

// Reset values; pin 5 is the top byte.
`define GMX_RST_CTRL     48'h902A29282700
`define GMX_RST_POL      6'h3F
`define GMX_RST_COLLA    24'h000000
`define GMX_RST_IMASK    6'h00

// Clock output: the reset rate is 1 MHz from the 20 MHz reference.
`define GMX_REF_CLK_HZ     20000000
`define GMX_CLKOUT_RST_HZ  1000000
`define GMX_CLKDIV_RST \
	8'((`GMX_REF_CLK_HZ / (2 * `GMX_CLKOUT_RST_HZ)) - 1)

`endif

// >>> rtl/gmx_pkg.sv
`include "gmx_cfg.svh"

package gmx_pkg;

	typedef struct packed {
		logic       dir_in;
		logic [6:0] code;
	} gmx_ctrl_t;

	typedef struct packed {
		logic [`GMX_ADDR_W-1:0] addr;
		logic [`GMX_DATA_W-1:0] wdata;
		logic                   wr;
		logic                   rd;
	} gmx_bus_req_t;

	typedef struct packed {
		logic [`GMX_NPINS-1:0] out;
		logic [`GMX_NPINS-1:0] oe;
	} gmx_pin_drv_t;

	typedef struct packed {
		logic meta;
		logic stable;
	} gmx_sync_state_t;

	typedef struct packed {
		logic [`GMX_DIV_W-1:0] cnt;
		logic                  lvl;
	} gmx_div_state_t;

	typedef struct packed {
		gmx_ctrl_t [`GMX_NPINS-1:0]   ctrl;
		logic [`GMX_NPINS-1:0]        pol;
		logic [`GMX_NFLAGS-1:0]       coll_a;
		logic [`GMX_DIV_W-1:0]        clk_div;
		logic [`GMX_NPINS-1:0]        int_stat;
		logic [`GMX_NPINS-1:0]        int_mask;
		logic [`GMX_NPINS-1:0]        lvl_prev;
		logic [6:0]                   last;
		logic [`GMX_DATA_W-1:0]       rdata;
		gmx_pin_drv_t                 drv;
		logic [`GMX_NSTROBES-1:0]     strobe;
		logic                         irq;
	} gmx_state_t;

endpackage : gmx_pkg

// >>> rtl/gmx_pin_sync.sv
`timescale 1ns/1ps

module gmx_pin_sync (
	// Clock and reset.
	input  wire logic ref_clk_i,
	input  wire logic srst_i,
	// Pin level and its synchronised copy.
	input  wire logic pin_i,
	output logic      level_o
);

	gmx_pkg::gmx_sync_state_t s_r;
	gmx_pkg::gmx_sync_state_t s_nxt;

	// The first stage feeds only the second stage.
	always_comb begin
		s_nxt.meta   = pin_i;
		s_nxt.stable = s_r.meta;
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign level_o = s_r.stable;

endmodule : gmx_pin_sync

// >>> rtl/gmx_clk_div.sv
`timescale 1ns/1ps

module gmx_clk_div (
	// Clock and reset.
	input  wire logic                  ref_clk_i,
	input  wire logic                  srst_i,
	// Half period minus one, in reference cycles.
	input  wire logic [`GMX_DIV_W-1:0] div_i,
	// Divided clock level.
	output logic                       clk_o
);

	gmx_pkg::gmx_div_state_t s_r;
	gmx_pkg::gmx_div_state_t s_nxt;

	// A lowered divisor below the running count wraps at once, so a new
	// setting never waits for a full counter roll-over.
	always_comb begin
		s_nxt = s_r;
		if (s_r.cnt >= div_i) begin
			s_nxt.cnt = '0;
			s_nxt.lvl = ~s_r.lvl;
		end else begin
			s_nxt.cnt = s_r.cnt + `GMX_DIV_W'(1);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign clk_o = s_r.lvl;

endmodule : gmx_clk_div

// >>> rtl/gmx_top.sv
// Notes on behaviour
// - Host writes the input code last; e.g. 0x88 gives transmit-on strobe.
// - Only the first sixteen codes launch strobes when the pin is input.
// - A strobe launches only on an edge matching the pin polarity.
// - Code 0x00: buffer-exchange strobe as input, clock out as output.
// - Input codes 0x01 to 0x07 map to the first seven listed strobes.
// - Input codes 0x08 to 0x0F map to the next eight listed strobes.
// - Output codes 0x01 to 0x08 drive the first eight exception flags.
// - Output codes 0x09 to 0x10 drive the next eight exception flags.
// - Output codes 0x11 to 0x18 drive the last eight exception flags.
// - Codes 0x10 and above launch no strobe on any edge.
// - Output code 0x21 is active while any flag in collection A is active.
// - All six pins share one code table, so any function suits any pin.
// - Control bit 7 selects input; the low seven bits select the function.
// - Polarity bit picks rising or falling edge, or output active level.
`timescale 1ns/1ps

module gmx_top (
	// Clock and reset.
	input  wire logic                      ref_clk_i,
	input  wire logic                      srst_i,
	// Register port.
	input  wire gmx_pkg::gmx_bus_req_t     bus_i,
	output logic [`GMX_DATA_W-1:0]         rdata_o,
	// Pins.
	input  wire logic [`GMX_NPINS-1:0]     pin_in_i,
	output logic [`GMX_NPINS-1:0]          pin_out_o,
	output logic [`GMX_NPINS-1:0]          pin_oe_o,
	// Exception flags from the radio core.
	input  wire logic [`GMX_NFLAGS-1:0]    exc_flags_i,
	// Command strobe requests, one-cycle pulses.
	output logic [`GMX_NSTROBES-1:0]       strobe_o,
	// Interrupt.
	output logic                           irq_o
);

	gmx_pkg::gmx_state_t            s_r;
	gmx_pkg::gmx_state_t            s_nxt;
	logic [`GMX_NPINS-1:0]          pin_lvl;
	logic                           clk_out;

	// True when the code carries a strobe meaning as an input.
	function automatic logic is_strobe_code(input logic [6:0] code);
		is_strobe_code = (code <= `GMX_CODE_STROBE_LAST);
	endfunction : is_strobe_code

	// True when the address hits one of the per-pin control registers.
	function automatic logic is_ctrl_addr(
		input logic [`GMX_ADDR_W-1:0] addr
	);
		is_ctrl_addr = (addr >= `GMX_A_CTRL0) && (addr < `GMX_A_POL);
	endfunction : is_ctrl_addr

	// Index of the addressed control register.
	function automatic logic [2:0] ctrl_index(
		input logic [`GMX_ADDR_W-1:0] addr
	);
		logic [`GMX_ADDR_W-1:0] diff;
		diff = addr - `GMX_A_CTRL0;
		ctrl_index = diff[2:0];
	endfunction : ctrl_index

	// Level of the internal signal that an output code selects.
	function automatic logic out_signal(
		input logic [6:0]             code,
		input logic [`GMX_NFLAGS-1:0] flags,
		input logic [`GMX_NFLAGS-1:0] coll,
		input logic                   clk
	);
		logic [6:0] idx;
		idx = code - `GMX_CODE_FLAG_FIRST;
		if (code == `GMX_CODE_CLOCK) begin
			out_signal = clk;
		end else if (code <= `GMX_CODE_FLAG_LAST) begin
			out_signal = flags[idx[4:0]];
		end else if (code == `GMX_CODE_COLL_A) begin
			out_signal = |(flags & coll);
		end else begin
			// Reserved and unsupported codes show the inactive level.
			out_signal = 1'b0;
		end
	endfunction : out_signal

	// Pin drive level, with the polarity applied.
	function automatic logic pin_level(
		input logic [6:0]             code,
		input logic                   pol,
		input logic [`GMX_NFLAGS-1:0] flags,
		input logic [`GMX_NFLAGS-1:0] coll,
		input logic                   clk
	);
		logic sig;
		sig = out_signal(code, flags, coll, clk);
		if (code == `GMX_CODE_DRIVE_LOW) begin
			// Constant low whatever the polarity, so the host can park
			// the pin before it turns the direction round.
			pin_level = 1'b0;
		end else begin
			pin_level = pol ? sig : ~sig;
		end
	endfunction : pin_level

	// Register read multiplexer.
	function automatic logic [`GMX_DATA_W-1:0] read_word(
		input logic [`GMX_ADDR_W-1:0] addr,
		input gmx_pkg::gmx_state_t    s,
		input logic [`GMX_NPINS-1:0]  lvl
	);
		read_word = '0;
		if (is_ctrl_addr(addr)) begin
			read_word[7:0] = s.ctrl[ctrl_index(addr)];
		end else begin
			unique case (addr)
				`GMX_A_POL: begin
					read_word[`GMX_NPINS-1:0] = s.pol;
				end
				`GMX_A_COLLA: begin
					read_word[`GMX_NFLAGS-1:0] = s.coll_a;
				end
				`GMX_A_CLKDIV: begin
					read_word[`GMX_DIV_W-1:0] = s.clk_div;
				end
				`GMX_A_ISTAT: begin
					read_word[`GMX_NPINS-1:0] = s.int_stat;
				end
				`GMX_A_IMASK: begin
					read_word[`GMX_NPINS-1:0] = s.int_mask;
				end
				`GMX_A_PINLVL: begin
					read_word[`GMX_NPINS-1:0] = lvl;
				end
				`GMX_A_LAST: begin
					read_word[6:0] = s.last;
				end
				default: begin
					read_word = '0;
				end
			endcase
		end
	endfunction : read_word

	// Every pin is synchronised on its own; no logic reads the first stage.
	generate
		for (genvar g = 0; g < `GMX_NPINS; g++) begin : g_sync
			gmx_pin_sync u_sync (
				.ref_clk_i (ref_clk_i),
				.srst_i    (srst_i),
				.pin_i     (pin_in_i[g]),
				.level_o   (pin_lvl[g])
			);
		end
	endgenerate

	gmx_clk_div u_div (
		.ref_clk_i (ref_clk_i),
		.srst_i    (srst_i),
		.div_i     (s_r.clk_div),
		.clk_o     (clk_out)
	);

	always_comb begin
		logic                  edge_seen;
		logic                  rise;
		logic                  fall;
		gmx_pkg::gmx_ctrl_t    c;
		edge_seen    = 1'b0;
		rise         = 1'b0;
		fall         = 1'b0;
		c            = '0;
		s_nxt        = s_r;
		s_nxt.strobe = '0;
		s_nxt.rdata  = '0;

		// Register writes.
		if (bus_i.wr) begin
			if (is_ctrl_addr(bus_i.addr)) begin
				s_nxt.ctrl[ctrl_index(bus_i.addr)] =
					bus_i.wdata[7:0];
			end else begin
				unique case (bus_i.addr)
					`GMX_A_POL: begin
						s_nxt.pol = bus_i.wdata[`GMX_NPINS-1:0];
					end
					`GMX_A_COLLA: begin
						s_nxt.coll_a = bus_i.wdata[`GMX_NFLAGS-1:0];
					end
					`GMX_A_CLKDIV: begin
						s_nxt.clk_div = bus_i.wdata[`GMX_DIV_W-1:0];
					end
					`GMX_A_IMASK: begin
						s_nxt.int_mask = bus_i.wdata[`GMX_NPINS-1:0];
					end
					default: begin
						s_nxt.rdata = '0;
					end
				endcase
			end
		end

		// Register reads; a read of the status register clears it.
		if (bus_i.rd) begin
			s_nxt.rdata = read_word(bus_i.addr, s_r, pin_lvl);
			if (bus_i.addr == `GMX_A_ISTAT) begin
				s_nxt.int_stat = '0;
			end
		end

		// Per-pin edge detection and output drive.
		for (int i = 0; i < `GMX_NPINS; i++) begin
			c    = s_r.ctrl[i];
			rise = pin_lvl[i] & ~s_r.lvl_prev[i];
			fall = ~pin_lvl[i] & s_r.lvl_prev[i];
			// A host that parks the pin low before the input code lands
			// gives no stray edge here.
			edge_seen = s_r.pol[i] ? rise : fall;
			if (c.dir_in && is_strobe_code(c.code) && edge_seen) begin
				// Code bits map straight to strobe index.
				s_nxt.strobe[c.code[3:0]] = 1'b1;
				// Setting here after the clear lets the event win.
				s_nxt.int_stat[i] = 1'b1;
				s_nxt.last = {i[2:0], c.code[3:0]};
			end
			s_nxt.lvl_prev[i] = pin_lvl[i];
			// Input mode releases the pin.
			s_nxt.drv.oe[i]  = ~c.dir_in;
			s_nxt.drv.out[i] = c.dir_in ? 1'b0 :
				pin_level(c.code, s_r.pol[i], exc_flags_i,
					s_r.coll_a, clk_out);
		end

		s_nxt.irq = |(s_nxt.int_stat & s_nxt.int_mask);
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			s_r          <= '0;
			s_r.ctrl     <= `GMX_RST_CTRL;
			s_r.pol      <= `GMX_RST_POL;
			s_r.coll_a   <= `GMX_RST_COLLA;
			s_r.clk_div  <= `GMX_CLKDIV_RST;
			s_r.int_mask <= `GMX_RST_IMASK;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata_o   = s_r.rdata;
	assign pin_out_o = s_r.drv.out;
	assign pin_oe_o  = s_r.drv.oe;
	assign strobe_o  = s_r.strobe;
	assign irq_o     = s_r.irq;

endmodule : gmx_top

// >>> test/gmx_chk.sv
`timescale 1ns/1ps
`include "gmx_cfg.svh"

module gmx_chk (
	// Clock and reset.
	input wire logic                  ref_clk_i,
	input wire logic                  srst_i,
	// Register port.
	input wire gmx_pkg::gmx_bus_req_t bus_i,
	input wire logic [31:0]           rdata_o,
	// Pins, flags, strobes and interrupt.
	input wire logic [5:0]            pin_in_i,
	input wire logic [5:0]            pin_out_o,
	input wire logic [5:0]            pin_oe_o,
	input wire logic [23:0]           exc_flags_i,
	input wire logic [15:0]           strobe_o,
	input wire logic                  irq_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);

	// A strobe needs a pin change three or four cycles earlier.
	chk_strobe_cause: assert property (
		strobe_o != 0 |-> $past(pin_in_i, 3) != $past(pin_in_i, 4)
		|| $past(pin_in_i, 4) != $past(pin_in_i, 5))
		else $error("strobe without pin edge");
	chk_strobe_pulse: assert property (
		strobe_o != 0 |=> (strobe_o & $past(strobe_o)) == 0)
		else $error("strobe longer than one cycle");
	chk_input_quiet: assert property (
		(pin_out_o & ~pin_oe_o) == 0)
		else $error("undriven pin shows a level");
	chk_irq_cause: assert property (
		$rose(irq_o) |-> strobe_o != 0 || $past(strobe_o) != 0
		|| $past(bus_i.wr) || $past(bus_i.wr, 2))
		else $error("interrupt rose without cause");
	chk_irq_clear: assert property (
		bus_i.rd && bus_i.addr == `GMX_A_ISTAT ##1 strobe_o == 0
		|-> !irq_o)
		else $error("interrupt kept after status read");
	chk_rdata_idle: assert property (
		!$past(bus_i.rd) |-> rdata_o == 0)
		else $error("read data outside read cycle");
	chk_rdata_unmapped: assert property (
		bus_i.rd && bus_i.addr > 4'hC |=> rdata_o == 0)
		else $error("unmapped read not zero");
	chk_reset_pins: assert property (
		$fell(srst_i) |-> pin_oe_o == 0 ##[1:2] pin_oe_o == 6'h1F)
		else $error("pin directions wrong after reset");
	chk_reset_quiet: assert property (
		$fell(srst_i) |-> strobe_o == 0 && !irq_o && rdata_o == 0)
		else $error("outputs busy after reset");

	cover property (strobe_o != 0);
	cover property ($rose(irq_o));
	cover property (exc_flags_i != 0 && pin_out_o != 0);
endmodule : gmx_chk

bind gmx_top gmx_chk u_chk (.ref_clk_i, .srst_i, .bus_i, .rdata_o,
	.pin_in_i, .pin_out_o, .pin_oe_o, .exc_flags_i, .strobe_o, .irq_o);

// >>> test/gmx_host.sv
`timescale 1ns/1ps
`include "gmx_cfg.svh"

module gmx_host (
	// Clock.
	input  wire logic             ref_clk_i,
	// Register port.
	output gmx_pkg::gmx_bus_req_t bus_o,
	input  wire logic [31:0]      rdata_i,
	// Levels the host puts on the pins.
	output logic [5:0]            lvl_o
);
	int gap = 0;

	initial begin
		bus_o = '0;
		lvl_o = '0;
	end

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		repeat (gap) @(posedge ref_clk_i);
		@(posedge ref_clk_i);
		bus_o <= {a, d, 2'b10};
		@(posedge ref_clk_i);
		bus_o.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		repeat (gap) @(posedge ref_clk_i);
		@(posedge ref_clk_i);
		bus_o <= {a, 32'h0, 2'b01};
		@(posedge ref_clk_i);
		bus_o.rd <= 1'b0;
		#1 d = rdata_i;
	endtask : rd

	task automatic set(input int p, input logic v);
		@(posedge ref_clk_i);
		lvl_o[p] <= v;
	endtask : set

	// The pin is held low on both sides before it turns into an input,
	// so the change of direction itself can never look like an edge.
	task automatic to_input(input int p, input logic [6:0] c);
		wr(4'(p), 32'h7E);
		set(p, 1'b0);
		// The parked low level needs the pin synchroniser and the edge
		// flop to settle before the input code lands. Otherwise the old
		// high level still looks like a falling edge.
		repeat (4) @(posedge ref_clk_i);
		wr(4'(p), {24'h0, 1'b1, c});
	endtask : to_input
endmodule : gmx_host

// >>> test/tb_top.sv
`timescale 1ns/1ps
`include "gmx_cfg.svh"
`define CHK(g, e) begin \
	num_checks++; \
	if ((g) !== (e)) begin \
		err_count++; \
		$display("Error at %0t: got %h want %h", $time, g, e); \
	end \
end

module tb_top;
	logic                  clk = 1'b0;
	logic                  srst = 1'b1;
	logic [23:0]           exc = '0;
	logic [23:0]           ca;
	logic [5:0]            pin, oe, out, hl;
	logic [31:0]           rdat, d;
	logic [15:0]           stb, seen;
	logic [6:0]            c;
	logic                  irq, pl, m;
	gmx_pkg::gmx_bus_req_t bus;
	int                    err_count, num_checks, nstb, p, k, n;

	always #25 clk = ~clk;
	assign pin = (oe & out) | (~oe & hl);
	always @(posedge clk) if (stb != 0) begin
		seen |= stb;
		nstb++;
	end

	gmx_top u_dut (.ref_clk_i(clk), .srst_i(srst), .bus_i(bus),
		.rdata_o(rdat), .pin_in_i(pin), .pin_out_o(out), .pin_oe_o(oe),
		.exc_flags_i(exc), .strobe_o(stb), .irq_o(irq));
	gmx_host u_host (.ref_clk_i(clk), .bus_o(bus), .rdata_i(rdat),
		.lvl_o(hl));

	function automatic logic [31:0] rv(int a);
		case (a)
			0, 1, 2, 3, 4, 5: return 32'(8'(`GMX_RST_CTRL >> (8 * a)));
			6: return 32'h3F;
			8: return 32'h9;
			default: return 32'h0;
		endcase
	endfunction : rv

	function automatic logic eo(logic [6:0] c, logic [23:0] f, a,
		logic pl);
		return (c == `GMX_CODE_COLL_A ? |(f & a) : f[c - 1]) ^ !pl;
	endfunction : eo

	task automatic tog(input int p, input logic v, input int k);
		#1 seen = '0;
		nstb = 0;
		u_host.set(p, v);
		repeat (8) @(posedge clk);
		#1 `CHK(seen, k < 0 ? 16'h0 : 16'h1 << k)
		`CHK(nstb, k < 0 ? 0 : 1)
	endtask : tog

	// The first change only realigns; the second may be a cut period.
	task automatic wchg(output int n);
		logic v;
		v = out[0];
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (out[0] === v && n < 600);
	endtask : wchg

	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		#2000000;
		err_count++;
		report_and_stop();
	end

	initial begin
		void'($urandom(32'h6B9A1B38));
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		for (int a = 0; a < 16; a++) if (a != 11) begin
			u_host.rd(4'(a), d);
			`CHK(d, rv(a))
		end
		u_host.wr(`GMX_A_ISTAT, 32'h3F);
		u_host.rd(`GMX_A_ISTAT, d);
		`CHK(d, 32'h0)
		$display("Test reset values done");
		for (int i = 0; i < 17; i++) begin
			p = $urandom_range(5);
			pl = 1'($urandom_range(1));
			m = 1'($urandom_range(1));
			c = i < 16 ? 7'(i) : 7'($urandom_range(24, 16));
			k = i < 16 ? i : -1;
			u_host.wr(`GMX_A_POL, 32'(pl) << p);
			u_host.wr(`GMX_A_IMASK, 32'(m) << p);
			u_host.to_input(p, c);
			tog(p, 1'b1, pl ? k : -1);
			tog(p, 1'b0, pl ? -1 : k);
			`CHK(oe[p], 1'b0)
			`CHK(irq, m && k >= 0)
			u_host.rd(`GMX_A_ISTAT, d);
			`CHK(d, 32'(k >= 0) << p)
			`CHK(irq, 1'b0)
			if (k >= 0) begin
				u_host.rd(`GMX_A_LAST, d);
				`CHK(d, 32'({3'(p), 4'(k)}))
			end
		end
		$display("Test input strobes done");
		u_host.gap = 1;
		for (int i = 1; i < 26; i++) begin
			p = $urandom_range(5);
			pl = 1'($urandom_range(1));
			c = i < 25 ? 7'(i) : `GMX_CODE_COLL_A;
			ca = 24'($urandom);
			u_host.wr(`GMX_A_COLLA, 32'(ca));
			u_host.wr(`GMX_A_POL, 32'(pl) << p);
			u_host.wr(4'(p), 32'(c));
			for (int j = 0; j < 2; j++) begin
				@(posedge clk);
				exc <= 24'($urandom);
				repeat (3) @(posedge clk);
				#1 `CHK(out[p], eo(c, exc, ca, pl))
				`CHK(oe[p], 1'b1)
			end
		end
		$display("Test output flags done");
		k = $urandom_range(6, 1);
		u_host.wr(`GMX_A_CLKDIV, 32'(k));
		u_host.wr(4'h0, 32'h0);
		wchg(n);
		wchg(n);
		wchg(n);
		`CHK(n, k + 1)
		$display("Test clock output done");
		report_and_stop();
	end
endmodule : tb_top
